// ==== rtl/bebs_defs.vh ====
`ifndef BEBS_DEFS_VH
`define BEBS_DEFS_VH

// Port width as reported by the width-request inputs.
`define BEBS_WIDTH_FULL 2'h0
`define BEBS_WIDTH_HALF 2'h1
`define BEBS_WIDTH_BYTE 2'h2

// Operand size codes on req_size.
`define BEBS_SIZE_BYTE  2'h0
`define BEBS_SIZE_WORD  2'h1
`define BEBS_SIZE_DWORD 2'h2

// Operand byte masks before they are moved to the operand offset.
`define BEBS_MASK_BYTE  8'h01
`define BEBS_MASK_WORD  8'h03
`define BEBS_MASK_DWORD 8'h0F

// Offset of the last operand byte from its first byte.
`define BEBS_LAST_BYTE  3'h0
`define BEBS_LAST_WORD  3'h1
`define BEBS_LAST_DWORD 3'h3

// Result keep masks for the response data.
`define BEBS_KEEP_BYTE  32'h000000FF
`define BEBS_KEEP_WORD  32'h0000FFFF
`define BEBS_KEEP_DWORD 32'hFFFFFFFF

// Highest programmed-I/O byte address.
`define BEBS_IO_LIMIT   32'h0000FFFF

// Reset and idle values of the bus pins and of the two-word data registers.
`define BEBS_LANES_IDLE 4'hF
`define BEBS_ADDR_RST   30'h00000000
`define BEBS_DATA_RST   32'h00000000
`define BEBS_WIDE_RST   64'h0000000000000000

`endif

// ==== rtl/bebs_lane_take.v ====
`timescale 1ns/1ps
`default_nettype none
`include "bebs_defs.vh"

module bebs_lane_take (
	// Pending lanes of this word and sampled port width
	input  wire [3:0] lanes,
	input  wire [1:0] width,
	// Lanes served by this cycle and lanes left for later
	output reg  [3:0] take,
	output wire [3:0] rest
);

	function [3:0] lowest_lane;
		input [3:0] m;
		begin
			lowest_lane = m & ((~m) + 4'h1);
		end
	endfunction

	wire [3:0] low;

	assign low = lowest_lane(lanes);

	// A half-width port only serves the half that holds the lowest pending lane.
	always @* begin
		case (width)
			`BEBS_WIDTH_BYTE: take = low;
			`BEBS_WIDTH_HALF: take = (|low[1:0]) ? (lanes & 4'h3) : (lanes & 4'hC);
			default: take = lanes;
		endcase
	end

	assign rest = lanes & ~take;

endmodule // bebs_lane_take

`default_nettype wire

// ==== rtl/bebs_op_place.v ====
`timescale 1ns/1ps
`default_nettype none
`include "bebs_defs.vh"

module bebs_op_place (
	// Operand offset inside its word, size and write data
	input  wire [1:0]  offs,
	input  wire [1:0]  size,
	input  wire [31:0] wdata,
	// Byte mask and data spread over two consecutive words
	output reg  [7:0]  mask,
	output wire [63:0] wide,
	output reg  [2:0]  last,
	output reg         bad_size
);

	reg [7:0] base;

	always @* begin
		bad_size = 1'b0;
		case (size)
			`BEBS_SIZE_BYTE: begin
				base = `BEBS_MASK_BYTE;
				last = `BEBS_LAST_BYTE;
			end
			`BEBS_SIZE_WORD: begin
				base = `BEBS_MASK_WORD;
				last = `BEBS_LAST_WORD;
			end
			`BEBS_SIZE_DWORD: begin
				base = `BEBS_MASK_DWORD;
				last = `BEBS_LAST_DWORD;
			end
			default: begin
				base = 8'h00;
				last = 3'h0;
				bad_size = 1'b1;
			end
		endcase
		mask = base << offs;
	end

	// Each byte keeps its own lane: the lowest address sits on lane 0.
	assign wide = {32'h00000000, wdata} << {offs, 3'h0};

endmodule // bebs_op_place

`default_nettype wire

// ==== rtl/bebs_bus_sizer.v ====
`timescale 1ns/1ps
`default_nettype none
`include "bebs_defs.vh"

module bebs_bus_sizer (
	// Clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// Operand request
	input  wire        req_valid,
	output wire        req_ready,
	input  wire [31:0] req_addr,
	input  wire [1:0]  req_size,
	input  wire        req_write,
	input  wire        req_io,
	input  wire [31:0] req_wdata,
	// Operand response
	output wire        rsp_valid,
	output wire        rsp_error,
	output wire [31:0] rsp_rdata,
	// Bus cycle control
	output wire        cycle_start_n,
	output wire        bus_write,
	output wire        bus_io,
	input  wire        bus_ready_n,
	// Address and lane selects
	output wire [29:0] word_address,
	output wire [3:0]  byte_lane_select_n,
	// Width requests from address decode
	input  wire        half_width_request_n,
	input  wire        byte_width_request_n,
	// Data bus, split into input, output and per-lane enable
	input  wire [31:0] data_in,
	output wire [31:0] data_out,
	output wire [3:0]  data_oe
);

	localparam [1:0] S_IDLE  = 2'h0;
	localparam [1:0] S_START = 2'h1;
	localparam [1:0] S_WAIT  = 2'h2;

	function [1:0] port_width;
		input half_n;
		input byte_n;
		begin
			if (!byte_n) begin
				port_width = `BEBS_WIDTH_BYTE;
			end else if (!half_n) begin
				port_width = `BEBS_WIDTH_HALF;
			end else begin
				port_width = `BEBS_WIDTH_FULL;
			end
		end
	endfunction

	// Only the selected lanes carry the write word; the others are zeroed.
	function [31:0] lane_data;
		input [3:0]  lanes;
		input [31:0] word;
		begin
			lane_data = word & {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}};
		end
	endfunction

	reg  [1:0]  state_q;
	reg         req_ready_q;
	reg         rsp_valid_q;
	reg         rsp_error_q;
	reg  [31:0] rsp_rdata_q;
	reg         cycle_start_n_q;
	reg         bus_write_q;
	reg         bus_io_q;
	reg  [29:0] word_address_q;
	reg  [3:0]  byte_lane_select_n_q;
	reg  [31:0] data_out_q;
	reg  [3:0]  data_oe_q;
	reg  [7:0]  mask_q;
	reg  [63:0] wide_q;
	reg  [63:0] rd_q;
	reg  [1:0]  offs_q;
	reg  [1:0]  size_q;
	reg         hi_word_q;

	wire [7:0]  op_mask;
	wire [63:0] op_wide;
	wire [2:0]  op_last;
	wire        op_bad_size;
	wire [32:0] op_end;
	wire        op_reject;
	wire        accept;
	wire [1:0]  width;
	wire [3:0]  cur_lanes;
	wire [3:0]  take;
	wire [3:0]  rest;
	wire        ended;
	wire        more;
	wire        hop;
	wire        cap_en;
	wire [63:0] rd_d;
	wire [63:0] rd_shift;
	reg  [31:0] keep;

	bebs_op_place u_place (
		.offs     (req_addr[1:0]),
		.size     (req_size),
		.wdata    (req_wdata),
		.mask     (op_mask),
		.wide     (op_wide),
		.last     (op_last),
		.bad_size (op_bad_size)
	);

	assign accept = req_valid & req_ready_q;
	assign op_end = {1'b0, req_addr} + {30'h00000000, op_last};

	// A wrap past the top of memory would continue at word 0, so it is refused.
	assign op_reject = op_bad_size | op_end[32] | (req_io & (op_end[31:0] > `BEBS_IO_LIMIT));

	// Width is sampled together with ready, on every cycle of a split.
	assign width     = port_width(half_width_request_n, byte_width_request_n);
	assign cur_lanes = ~byte_lane_select_n_q;

	bebs_lane_take u_take (
		.lanes (cur_lanes),
		.width (width),
		.take  (take),
		.rest  (rest)
	);

	assign ended = (state_q == S_WAIT) & ~bus_ready_n;
	assign more  = |rest;
	assign hop   = ~hi_word_q & (|mask_q[7:4]);
	assign cap_en = ended & ~bus_write_q;

	// Read bytes are caught on their own lanes into a two-word image.
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_cap
			wire hit;
			assign hit = cap_en & take[gi % 4] & (hi_word_q == (gi >= 4));
			assign rd_d[gi * 8 + 7:gi * 8] = hit ? data_in[(gi % 4) * 8 + 7:(gi % 4) * 8] : rd_q[gi * 8 + 7:gi * 8];
		end
	endgenerate

	assign rd_shift = rd_d >> {offs_q, 3'h0};

	always @* begin
		case (size_q)
			`BEBS_SIZE_BYTE: keep = `BEBS_KEEP_BYTE;
			`BEBS_SIZE_WORD: keep = `BEBS_KEEP_WORD;
			default: keep = `BEBS_KEEP_DWORD;
		endcase
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			state_q              <= S_IDLE;
			req_ready_q          <= 1'b0;
			rsp_valid_q          <= 1'b0;
			rsp_error_q          <= 1'b0;
			rsp_rdata_q          <= `BEBS_DATA_RST;
			cycle_start_n_q      <= 1'b1;
			bus_write_q          <= 1'b0;
			bus_io_q             <= 1'b0;
			word_address_q       <= `BEBS_ADDR_RST;
			byte_lane_select_n_q <= `BEBS_LANES_IDLE;
			data_out_q           <= `BEBS_DATA_RST;
			data_oe_q            <= 4'h0;
			mask_q               <= 8'h00;
			wide_q               <= `BEBS_WIDE_RST;
			rd_q                 <= `BEBS_WIDE_RST;
			offs_q               <= 2'h0;
			size_q               <= 2'h0;
			hi_word_q            <= 1'b0;
		end else begin
			rsp_valid_q <= 1'b0;
			rd_q        <= rd_d;
			case (state_q)
				S_IDLE: begin
					req_ready_q <= 1'b1;
					if (accept) begin
						if (op_reject) begin
							rsp_valid_q <= 1'b1;
							rsp_error_q <= 1'b1;
							rsp_rdata_q <= `BEBS_DATA_RST;
						end else begin
							req_ready_q          <= 1'b0;
							state_q              <= S_START;
							mask_q               <= op_mask;
							wide_q               <= op_wide;
							rd_q                 <= `BEBS_WIDE_RST;
							offs_q               <= req_addr[1:0];
							size_q               <= req_size;
							hi_word_q            <= 1'b0;
							bus_write_q          <= req_write;
							bus_io_q             <= req_io;
							cycle_start_n_q      <= 1'b0;
							word_address_q       <= req_addr[31:2];
							byte_lane_select_n_q <= ~op_mask[3:0];
							data_out_q           <= req_write ? lane_data(op_mask[3:0], op_wide[31:0]) :
							                        `BEBS_DATA_RST;
							data_oe_q            <= req_write ? op_mask[3:0] : 4'h0;
						end
					end
				end
				S_START: begin
					cycle_start_n_q <= 1'b1;
					state_q         <= S_WAIT;
				end
				S_WAIT: begin
					// Address, lanes and data stay put until ready is seen.
					if (ended) begin
						if (more) begin
							state_q              <= S_START;
							cycle_start_n_q      <= 1'b0;
							byte_lane_select_n_q <= ~rest;
							data_out_q           <= bus_write_q ?
							                        lane_data(rest, hi_word_q ? wide_q[63:32] : wide_q[31:0]) :
							                        `BEBS_DATA_RST;
							data_oe_q            <= bus_write_q ? rest : 4'h0;
						end else if (hop) begin
							state_q              <= S_START;
							cycle_start_n_q      <= 1'b0;
							hi_word_q            <= 1'b1;
							word_address_q       <= word_address_q + 30'h00000001;
							byte_lane_select_n_q <= ~mask_q[7:4];
							data_out_q           <= bus_write_q ? lane_data(mask_q[7:4], wide_q[63:32]) :
							                        `BEBS_DATA_RST;
							data_oe_q            <= bus_write_q ? mask_q[7:4] : 4'h0;
						end else begin
							state_q              <= S_IDLE;
							rsp_valid_q          <= 1'b1;
							rsp_error_q          <= 1'b0;
							rsp_rdata_q          <= bus_write_q ? `BEBS_DATA_RST : (rd_shift[31:0] & keep);
							byte_lane_select_n_q <= `BEBS_LANES_IDLE;
							data_out_q           <= `BEBS_DATA_RST;
							data_oe_q            <= 4'h0;
						end
					end
				end
				default: begin
					state_q              <= S_IDLE;
					cycle_start_n_q      <= 1'b1;
					byte_lane_select_n_q <= `BEBS_LANES_IDLE;
					data_oe_q            <= 4'h0;
				end
			endcase
		end
	end

	assign req_ready          = req_ready_q;
	assign rsp_valid          = rsp_valid_q;
	assign rsp_error          = rsp_error_q;
	assign rsp_rdata          = rsp_rdata_q;
	assign cycle_start_n      = cycle_start_n_q;
	assign bus_write          = bus_write_q;
	assign bus_io             = bus_io_q;
	assign word_address       = word_address_q;
	assign byte_lane_select_n = byte_lane_select_n_q;
	assign data_out           = data_out_q;
	assign data_oe            = data_oe_q;

endmodule // bebs_bus_sizer

`default_nettype wire

// ==== verif/bebs_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module bebs_monitor (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// Bus cycle
	input wire logic        cycle_start_n,
	input wire logic        bus_write,
	input wire logic        bus_ready_n,
	input wire logic [29:0] word_address,
	input wire logic [3:0]  byte_lane_select_n,
	input wire logic        half_width_request_n,
	input wire logic        byte_width_request_n,
	input wire logic [31:0] data_out,
	input wire logic [3:0]  data_oe
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	logic        wait_q;
	logic [69:0] snap_q;
	wire  [3:0]  lanes = ~byte_lane_select_n;
	wire  [3:0]  drop  = lanes & (lanes - 4'h1);
	wire  [69:0] pins  = {word_address, byte_lane_select_n, data_out, data_oe};
	wire  [31:0] selb  = {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}};
	wire         spans = lanes[1:0] != 2'h0 && lanes[3:2] != 2'h0;
	always @(posedge clk) begin
		if (!rst_n)
			wait_q <= 1'b0;
		else if (!cycle_start_n)
			wait_q <= 1'b1;
		else if (!bus_ready_n)
			wait_q <= 1'b0;
		if (!cycle_start_n)
			snap_q <= pins;
	end
	// Ready edge of a cycle, and a follow-on start in the same word right after it.
	sequence s_rdy;
		wait_q && cycle_start_n && !bus_ready_n;
	endsequence
	sequence s_same;
		!cycle_start_n && word_address == $past(word_address);
	endsequence
	a_lanes_contig: assert property (
		!cycle_start_n |-> lanes inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hC, 4'h7, 4'hE, 4'hF})
		else $error("lane selects not contiguous");
	a_cycle_hold: assert property (wait_q && cycle_start_n |-> pins == snap_q)
		else $error("bus pins moved inside a cycle");
	a_write_lanes: assert property (
		wait_q || !cycle_start_n |-> (data_oe & ~lanes) == 4'h0 && (data_out & ~selb) == 32'h0)
		else $error("write data outside selected lanes");
	a_write_drive: assert property (!cycle_start_n |-> data_oe == (bus_write ? lanes : 4'h0))
		else $error("lane drive does not match selects");
	a_byte_next: assert property (
		s_rdy ##0 (!byte_width_request_n && drop != 4'h0) |=> s_same ##0 lanes == $past(drop))
		else $error("wrong follow-on lanes for byte port");
	a_byte_last: assert property (
		s_rdy ##0 (!byte_width_request_n && drop == 4'h0) |=> cycle_start_n || word_address != $past(word_address))
		else $error("extra cycle after last byte");
	a_half_next: assert property (
		s_rdy ##0 (byte_width_request_n && !half_width_request_n && spans) |=> s_same ##0 lanes == ($past(lanes) & 4'hC))
		else $error("wrong follow-on lanes for half port");
	a_served_last: assert property (
		s_rdy ##0 (byte_width_request_n && (!spans || half_width_request_n))
		|=> cycle_start_n || word_address != $past(word_address))
		else $error("extra cycle after served lanes");
endmodule // bebs_monitor
`default_nettype wire

// ==== verif/bebs_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module bebs_mem_model (
	// Clock and reset
	input wire logic         clk,
	input wire logic         rst_n,
	// Port width (0 full, 1 half, 2 byte, 3 both) and wait states
	input wire logic  [1:0]  mode,
	input wire logic  [1:0]  lat,
	// Bus from the sizer
	input wire logic         cycle_start_n,
	input wire logic  [29:0] word_address,
	input wire logic  [3:0]  byte_lane_select_n,
	input wire logic  [31:0] data_out,
	input wire logic  [3:0]  data_oe,
	// Answers to the sizer
	output var logic         bus_ready_n,
	output var logic         half_width_request_n,
	output var logic         byte_width_request_n,
	output var logic  [31:0] data_in
);
	logic [31:0] mem [0:15];
	logic        busy_q;
	logic [1:0]  cnt_q;
	wire  [3:0]  lanes = ~byte_lane_select_n;
	wire  [3:0]  low   = lanes & ~(lanes - 4'h1);
	// A narrow port serves only part of the lanes and garbles the rest.
	wire  [3:0]  srv   = mode[1] ? low : (mode[0] ? (low[1:0] != 2'h0 ? 4'h3 : 4'hC) & lanes : lanes);
	wire  [31:0] srvb  = {{8{srv[3]}}, {8{srv[2]}}, {8{srv[1]}}, {8{srv[0]}}};
	wire  [31:0] word  = mem[word_address[3:0]];
	initial {bus_ready_n, half_width_request_n, byte_width_request_n, data_in} = 35'h7_0000_0000;
	always @(posedge clk) begin
		if (!rst_n) begin
			busy_q <= 1'b0;
			bus_ready_n <= 1'b1;
		end else if (!bus_ready_n) begin
			// A released bus must not keep showing its last value.
			busy_q <= 1'b0;
			bus_ready_n <= 1'b1;
			data_in <= ~data_in;
			{half_width_request_n, byte_width_request_n} <= ~{half_width_request_n, byte_width_request_n};
			for (int i = 0; i < 4; i++)
				if (srv[i] && data_oe[i])
					mem[word_address[3:0]][8*i+:8] <= data_out[8*i+:8];
		end else if (!cycle_start_n) begin
			busy_q <= 1'b1;
			cnt_q <= lat;
		end else if (busy_q && cnt_q != 2'h0) begin
			cnt_q <= cnt_q - 2'h1;
		end else if (busy_q) begin
			bus_ready_n <= 1'b0;
			{half_width_request_n, byte_width_request_n} <= ~{mode[0], mode[1]};
			data_in <= (word & srvb) | (~word & ~srvb);
		end
	end
endmodule // bebs_mem_model
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "bebs_defs.vh"
module tb_top;
	logic        clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0, req_io = 1'b0;
	logic [1:0]  req_size = 2'h0, mode = 2'h0, lat = 2'h0;
	logic [31:0] req_addr = 32'h0, req_wdata = 32'h0;
	int          n_fail = 0, check_count = 0, cyc_cnt = 0, tick = 0;
	wire         req_ready, rsp_valid, rsp_error, cycle_start_n, bus_write, bus_io, bus_ready_n;
	wire         half_width_request_n, byte_width_request_n;
	wire  [31:0] rsp_rdata, data_in, data_out;
	wire  [29:0] word_address;
	wire  [3:0]  byte_lane_select_n, data_oe;
	bebs_bus_sizer i_bebs_bus_sizer (.clk, .rst_n, .req_valid, .req_ready, .req_addr, .req_size, .req_write,
		.req_io, .req_wdata, .rsp_valid, .rsp_error, .rsp_rdata, .cycle_start_n, .bus_write, .bus_io, .bus_ready_n,
		.word_address, .byte_lane_select_n, .half_width_request_n, .byte_width_request_n, .data_in, .data_out, .data_oe);
	bebs_mem_model i_bebs_mem_model (.clk, .rst_n, .mode, .lat, .cycle_start_n, .word_address, .byte_lane_select_n,
		.data_out, .data_oe, .bus_ready_n, .half_width_request_n, .byte_width_request_n, .data_in);
	always #2 clk = ~clk;
	always @(posedge clk) begin
		tick <= tick + 1;
		if (cycle_start_n === 1'b0)
			cyc_cnt <= cyc_cnt + 1;
		if (tick == 20000) begin
			n_fail++;
			end_sim();
		end
	end
	task automatic end_sim();
		if (n_fail == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Bus cycles a port of mode m needs, summed over the two words an operand may touch.
	function automatic int ncy(input logic [31:0] a, input logic [1:0] sz, input logic [1:0] m);
		logic [7:0] msk;
		logic [3:0] w;
		int         n;
		msk = (sz == `BEBS_SIZE_BYTE ? `BEBS_MASK_BYTE : (sz == `BEBS_SIZE_WORD ? `BEBS_MASK_WORD : `BEBS_MASK_DWORD));
		msk = msk << a[1:0];
		n = 0;
		for (int i = 0; i < 2; i++) begin
			w = msk[4*i+:4];
			n += m == 2'h0 ? int'(w != 4'h0) : (m == 2'h1 ? (w[1:0] != 2'h0) + (w[3:2] != 2'h0) : $countones(w));
		end
		return n;
	endfunction
	task automatic op(input logic [31:0] a, input logic [1:0] sz, input logic wr, input logic io,
		input logic [31:0] wd, input logic err, input int n, input logic [31:0] exp);
		int t;
		t = 0;
		@(posedge clk);
		{req_valid, req_addr, req_size, req_write, req_io, req_wdata} <= {1'b1, a, sz, wr, io, wd};
		do
			@(posedge clk);
		while (req_ready !== 1'b1);
		req_valid <= 1'b0;
		cyc_cnt = 0;
		do begin
			@(posedge clk);
			t++;
			if (t == 1 && !err) begin
				chk("bus_io", bus_io, io);
				chk("bus_write", bus_write, wr);
			end
		end while (rsp_valid !== 1'b1 && t < 300);
		// A response that never comes must not pass on stale response values.
		if (t >= 300)
			n_fail++;
		chk("rsp_error", rsp_error, err);
		chk("rsp_rdata", rsp_rdata, exp);
		chk("bus_cycles", cyc_cnt, n);
	endtask
	task automatic t_reset();
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		chk("lanes_idle", byte_lane_select_n, `BEBS_LANES_IDLE);
		chk("oe_idle", data_oe, 4'h0);
	endtask
	task automatic t_sizing();
		logic [31:0] a, wd, keep;
		for (int m = 0; m < 4; m++)
			for (int s = 0; s < 3; s++)
				for (int o = 0; o < 4; o++) begin
					a = 32'h100 + o;
					wd = 32'h9E3779B9 * (m * 12 + s * 4 + o + 1);
					keep = s == 0 ? `BEBS_KEEP_BYTE : (s == 1 ? `BEBS_KEEP_WORD : `BEBS_KEEP_DWORD);
					mode <= 2'(m);
					lat <= 2'(o);
					op(a, 2'(s), 1'b1, 1'b0, wd, 1'b0, ncy(a, 2'(s), 2'(m)), 32'h0);
					op(a, 2'(s), 1'b0, 1'b0, wd, 1'b0, ncy(a, 2'(s), 2'(m)), wd & keep);
				end
	endtask
	task automatic t_refuse();
		mode <= 2'h0;
		op(32'h0, 2'h3, 1'b0, 1'b0, 32'h0, 1'b1, 0, 32'h0);
		op(32'h0000FFFD, `BEBS_SIZE_DWORD, 1'b0, 1'b1, 32'h0, 1'b1, 0, 32'h0);
		op(32'hFFFFFFFE, `BEBS_SIZE_DWORD, 1'b1, 1'b0, 32'h0, 1'b1, 0, 32'h0);
		op(32'h0000FFFC, `BEBS_SIZE_DWORD, 1'b1, 1'b1, 32'h5A6B7C8D, 1'b0, 1, 32'h0);
		op(32'h0000FFFC, `BEBS_SIZE_DWORD, 1'b0, 1'b1, 32'h0, 1'b0, 1, 32'h5A6B7C8D);
	endtask
	initial begin
		t_reset();
		t_sizing();
		t_refuse();
		end_sim();
	end
endmodule // tb_top
bind bebs_bus_sizer bebs_monitor i_bebs_monitor (.clk(clk), .rst_n(rst_n), .cycle_start_n(cycle_start_n),
	.bus_write(bus_write), .bus_ready_n(bus_ready_n), .word_address(word_address),
	.byte_lane_select_n(byte_lane_select_n), .half_width_request_n(half_width_request_n),
	.byte_width_request_n(byte_width_request_n), .data_out(data_out), .data_oe(data_oe));
`default_nettype wire
